// file: bench/rx_line_model.sv
// far-side line receiver model: alternate marks, or silence on request.
// assumes the bench raises quiet to send a run of zeros.
`timescale 1ns/1ps
`default_nettype none
module rx_line_model
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic quiet,
    output logic pos,
    output logic neg,
    output logic bit_en
);
    logic ph_r;
    // pins move with each bit; alternating marks avoid code violations
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_r <= 1'b0;
            pos <= 1'b0;
            neg <= 1'b0;
            bit_en <= 1'b0;
        end
        else
        begin
            bit_en <= ~bit_en;
            if (!bit_en)
            begin
                ph_r <= ~ph_r;
                pos <= !quiet && !ph_r;
                neg <= !quiet && ph_r;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/rx_status_bank_tb.sv
// bench for the receive status bank: bus tasks, line model, strobes.
// assumes a 20-cycle multiframe timer and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module rx_status_bank_tb;
    logic ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rr;
    logic awready, wready, bvalid, arready, rvalid, bstb, fbit, rxb;
    logic [2:0] cond, bidx, pos_sel, sp_sel;
    logic [4:0] stb, err;
    logic quiet, pos, neg, ben, ibo_en, bdir, bfrm, ben_p, slong, los;
    logic e1, bdat, bval, irq, crc4;
    logic [7:0] onehot, supp;
    logic [3:0] sbits;
    logic [9:0] regs [6] = '{10'h088, 10'h089, 10'h08A, 10'h08B, 10'h090,
        10'h091};
    logic [7:0] dm [3] = '{8'h08, 8'h04, 8'h01};
    int error_cnt, check_count, cyc, n;

    rx_status_bank #(.MF_TIMER_CYCLES(20)) i_rx_status_bank (
        .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .line_rx_pos_input(pos),
        .line_rx_neg_input(neg), .line_bit_en(ben),
        .remote_alarm_cond(cond[0]), .all_ones_alarm_cond(cond[1]),
        .frame_loss_cond(cond[2]), .framing_bit_strobe(stb[0]),
        .framing_bit_error(err[0]), .crc_word_strobe(stb[3]),
        .crc_word_error(err[3]), .cas_mfas_strobe(stb[1]),
        .cas_mfas_error(err[1]), .fas_strobe(stb[2]), .fas_error(err[2]),
        .ts16_strobe(1'b0), .ts16_data(8'h00), .cas_mf_start(1'b0),
        .crc4_enable(crc4), .crc4_mf_boundary(stb[4]),
        .bert_bit_strobe(bstb), .bert_fbit(fbit), .bert_bit_index(bidx),
        .rx_framer_bit(rxb), .tx_path_bit(~rxb),
        .interleave_bus_enable(ibo_en), .bus_position_select(pos_sel),
        .bus_slot_onehot(onehot), .spare_code_length_sel(sp_sel),
        .spare_code_bits(sbits), .spare_code_long(slong),
        .bert_source_direction(bdir), .bert_framing_select(bfrm),
        .bert_port_enable(ben_p), .chan_bit_suppress(supp),
        .signal_loss_cond(los), .e1_mode(e1), .bert_bit_data(bdat),
        .bert_bit_valid(bval), .irq_req(irq));

    rx_line_model i_rx_line_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .quiet(quiet), .pos(pos), .neg(neg), .bit_en(ben));

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, got,
                exp);
        end
    endtask

    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask

    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [9:0] idx);
        @(posedge ref_clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
        rd_reg(idx);
        chk(rd, exp);
    endtask

    task automatic ev(input int k, input logic e);
        @(posedge ref_clk);
        stb[k] <= 1'b1;
        err[k] <= e;
        @(posedge ref_clk);
        stb <= 5'h00;
    endtask

    // one bert bit; valid is looked at in its single cycle
    task automatic bert(input logic f, input logic [2:0] i, input logic d,
        input logic v, input logic e);
        @(posedge ref_clk);
        bstb <= 1'b1;
        fbit <= f;
        bidx <= i;
        rxb <= d;
        @(posedge ref_clk);
        bstb <= 1'b0;
        @(negedge ref_clk);
        chk({bval, v ? bdat : 1'b0}, {v, e});
    endtask

    // clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, bstb, fbit, rxb} = '0;
        {awaddr, araddr, wdata, cond, bidx, stb, err, quiet, crc4} = '0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        foreach (regs[i]) rc(regs[i], 32'h0); // reset values
        rd_reg(10'h0FF);
        chk({rr, rd[29:0]}, {2'h2, 30'h0});
        wr(10'h0FF, 8'h00);
        chk(bresp, 2'h2);
        wr(10'h088, 8'h0D);
        settle();
        chk({ibo_en, pos_sel, onehot}, {1'b1, 3'h5, 8'h20});
        wr(10'h088, 8'h05);
        settle();
        chk({ibo_en, onehot}, {1'b0, 8'h00});
        for (int k = 0; k < 8; k++)
        begin
            wr(10'h089, 8'(k));
            settle();
            chk({slong, sbits, sp_sel}, {k == 7, k == 7 ? 4'h8 : 4'(k + 1),
                3'(k)});
        end
        wr(10'h08A, 8'h01);
        settle();
        chk({bdir, bfrm, ben_p}, 3'h1);
        bert(1'b0, 3'h3, 1'b1, 1'b1, 1'b1);
        bert(1'b1, 3'h3, 1'b1, 1'b0, 1'b0);
        wr(10'h08A, 8'h07);
        bert(1'b1, 3'h3, 1'b1, 1'b1, 1'b0);
        wr(10'h08B, 8'h80);
        chk(supp, 8'h80);
        bert(1'b0, 3'h7, 1'b1, 1'b0, 1'b0);
        bert(1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
        wr(10'h08A, 8'h06);
        bert(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge ref_clk);
            cond[i] <= 1'b1;
            settle();
            rc(10'h090, 32'(dm[i]));
            chk(irq, 1'b1);
            cond[i] <= 1'b0;
            settle();
            rc(10'h090, 32'({dm[i][3:0], dm[i][3:0]}));
            wr(10'h090, 8'hFF);
            rc(10'h090, 32'h0);
        end
        // silence the line and count bits until loss of signal
        quiet <= 1'b1;
        n = 0;
        while (los !== 1'b1)
        begin
            @(posedge ref_clk);
            if (ben) n++;
        end
        chk(n >= 192 && n <= 195, 1'b1);
        quiet <= 1'b0;
        repeat (12) @(negedge ref_clk);
        rc(10'h090, 32'h22);
        rc(10'h091, 32'h98);
        wr(10'h090, 8'hFF);
        settle();
        chk(irq, 1'b0);
        wr(10'h091, 8'hFF);
        rc(10'h091, 32'h0);
        repeat (3) ev(0, 1'b0);
        rc(10'h091, 32'h0);
        ev(0, 1'b1);
        ev(0, 1'b0);
        rc(10'h091, 32'h01);
        ev(0, 1'b1);
        rc(10'h091, 32'h05);
        wr(10'h0A0, 8'h01);
        settle();
        chk(e1, 1'b1);
        repeat (2) ev(2, 1'b1);
        ev(1, 1'b1);
        rd_reg(10'h091);
        chk(rd & 32'hF0, 32'h0);
        ev(2, 1'b1);
        ev(1, 1'b1);
        rd_reg(10'h091);
        chk(rd & 32'hF0, 32'h30);
        wr(10'h091, 8'hFF);
        repeat (30) @(negedge ref_clk);
        rd_reg(10'h091);
        chk(rd & 32'h02, 32'h02);
        chk(irq, 1'b1);
        crc4 <= 1'b1;
        wr(10'h091, 8'hFF);
        repeat (915) ev(3, 1'b1);
        ev(4, 1'b0);
        rd_reg(10'h091);
        chk(rd & 32'h40, 32'h40);
        chk(rd & 32'h02, 32'h02);
        complete_run();
    end
endmodule
`default_nettype wire

// file: rtl/rx_status_bank.sv
// receive control and latched-status bank of one framer port, with an
// AXI4-Lite register slave. line pins are asynchronous; every other
// input comes from framer logic or the AXI4-Lite bus on ref_clk.
// Notes on behaviour
// - interleave bus runs only while enabled
// - position field k selects bus slot k+1
// - spare code length k+1, code 7 long
// - BERT source framer, or transmit path
// - T1 F-bit used only when framing select
// - BERT port active only while enabled
// - suppress bit n removes channel bit n+1
// - first latched register bits latch, interrupt
// - rising edge detect, falling edge clear flags
// - loss of signal after 192 zeros
// - T1 event register never interrupts
// - T1 pulse density violation event latches
// - T1 eight and sixteen zero run events
// - T1 two of six framing bits errored
// - B8ZS codeword event in any coding
// - T1 each errored framing bit latches
// - E1 event bits latch, bits 3..0 interrupt
// - E1 915 of 1000 CRC words errored
// - E1 two CAS, three FAS errored words
// - E1 time slot 16 under three zeros
// - E1 time slot 16 zero whole multiframe
// - E1 multiframe event, 2 ms when no CRC-4
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_defs.svh"

module rx_status_bank
    import rx_status_pkg::*;
#(
    parameter int unsigned MF_TIMER_CYCLES = `MF_PERIOD_US * `CLK_MHZ
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic line_rx_pos_input,
    input wire logic line_rx_neg_input,
    input wire logic line_bit_en,
    input wire logic remote_alarm_cond,
    input wire logic all_ones_alarm_cond,
    input wire logic frame_loss_cond,
    input wire logic framing_bit_strobe,
    input wire logic framing_bit_error,
    input wire logic crc_word_strobe,
    input wire logic crc_word_error,
    input wire logic cas_mfas_strobe,
    input wire logic cas_mfas_error,
    input wire logic fas_strobe,
    input wire logic fas_error,
    input wire logic ts16_strobe,
    input wire logic [7:0] ts16_data,
    input wire logic cas_mf_start,
    input wire logic crc4_enable,
    input wire logic crc4_mf_boundary,
    input wire logic bert_bit_strobe,
    input wire logic bert_fbit,
    input wire logic [2:0] bert_bit_index,
    input wire logic rx_framer_bit,
    input wire logic tx_path_bit,
    output logic interleave_bus_enable,
    output logic [2:0] bus_position_select,
    output logic [7:0] bus_slot_onehot,
    output logic [2:0] spare_code_length_sel,
    output logic [3:0] spare_code_bits,
    output logic spare_code_long,
    output logic bert_source_direction,
    output logic bert_framing_select,
    output logic bert_port_enable,
    output logic [7:0] chan_bit_suppress,
    output logic signal_loss_cond,
    output logic e1_mode,
    output logic bert_bit_data,
    output logic bert_bit_valid,
    output logic irq_req
);

    bank_state_t s;
    bank_state_t n;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [3:0] cond;
    logic [1:0] pol;
    logic line_zero;

    // ones in a byte; used for framing error and slot 16 zero counts
    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction

    always_comb
    begin
        n = s;
        set1 = 8'h00;
        set2 = 8'h00;
        clr1 = 8'h00;
        clr2 = 8'h00;
        // line pins: two flops before any logic
        n.pos_s1 = line_rx_pos_input;
        n.pos_s2 = s.pos_s1;
        n.neg_s1 = line_rx_neg_input;
        n.neg_s2 = s.neg_s1;
        line_zero = !s.pos_s2 && !s.neg_s2;
        pol = 2'h0;

        // write channels may arrive in either order
        if (s.awready && s_axi_awvalid)
        begin
            n.aw_got = 1'b1;
            n.aw_idx = s_axi_awaddr[11:2];
        end
        if (s.wready && s_axi_wvalid)
        begin
            n.w_got = 1'b1;
            n.wbyte = s_axi_wdata[7:0];
            n.wlane = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OKAY;
            // only byte lane 0 carries register bits
            case (s.aw_idx)
                `IDX_IBO_CTL: if (s.wlane) n.ibo = s.wbyte[3:0];
                `IDX_SPARE_CTL: if (s.wlane) n.spare = s.wbyte[2:0];
                `IDX_BERT_CTL: if (s.wlane) n.bert_ctl = s.wbyte[2:0];
                `IDX_BERT_SUPPRESS: if (s.wlane) n.suppress = s.wbyte;
                `IDX_ALARM_STATUS: if (s.wlane) clr1 = s.wbyte;
                `IDX_EVENT_STATUS: if (s.wlane) clr2 = s.wbyte;
                `IDX_CODE_STATUS: ;
                `IDX_LINE_MODE:
                    if (s.wlane) n.e1_mode = s.wbyte[`E1_MODE_BIT];
                default: n.bresp = `RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // read: data captured at the address handshake
        if (s.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid)
        begin
            n.rvalid = 1'b1;
            n.rresp = `RESP_OKAY;
            n.rdata = 32'h0000_0000;
            case (s_axi_araddr[11:2])
                `IDX_IBO_CTL: n.rdata[3:0] = s.ibo;
                `IDX_SPARE_CTL: n.rdata[2:0] = s.spare;
                `IDX_BERT_CTL: n.rdata[2:0] = s.bert_ctl;
                `IDX_BERT_SUPPRESS: n.rdata[7:0] = s.suppress;
                `IDX_ALARM_STATUS: n.rdata[7:0] = s.rx_latched_alarm_status;
                `IDX_EVENT_STATUS: n.rdata[7:0] = s.rls2;
                `IDX_CODE_STATUS: ;
                `IDX_LINE_MODE: n.rdata[`E1_MODE_BIT] = s.e1_mode;
                default: n.rresp = `RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;

        n.bus_slot = n.ibo[`IBO_EN_BIT] ? (8'h01 << n.ibo[2:0]) : 8'h00;
        // code 7 means the long 8/16 bit code
        n.spare_long = (n.spare == 3'h7);
        n.spare_len = n.spare_long ? 4'h8 : ({1'b0, n.spare} + 4'h1);

        // zero runs and codewords, one step per line bit
        if (line_bit_en)
        begin
            if (line_zero)
            begin
                if (s.zero_cnt != 8'hFF)
                begin
                    n.zero_cnt = s.zero_cnt + 8'h01;
                end
            end
            else
            begin
                n.zero_cnt = 8'h00;
            end
            // loss of signal at 192 zeros
            if (n.zero_cnt == `LOS_ZEROS)
            begin
                n.los = 1'b1;
            end
            if (!line_zero)
            begin
                n.los = 1'b0;
            end
            if (!s.e1_mode && line_zero)
            begin
                // fires once per run, however long
                if (n.zero_cnt == `ZERO_RUN_SHORT)
                begin
                    set2[`EV_ZERO8_BIT] = 1'b1;
                end
                if (n.zero_cnt == `ZERO_RUN_LONG)
                begin
                    set2[`EV_ZERO16_BIT] = 1'b1;
                    // more than 15 zeros breaks density
                    set2[`EV_PDV_BIT] = 1'b1;
                end
            end
            // polarity of the last pulse before the window
            if (s.sym_hist[15:14] != 2'h0)
            begin
                n.pol_before = s.sym_hist[15];
            end
            n.sym_hist = {s.sym_hist[13:0], s.pos_s2, s.neg_s2};
            pol = n.pol_before ? 2'h2 : 2'h1;
            if (!s.e1_mode && n.sym_hist == {6'h00, pol, ~pol, 2'h0, ~pol, pol})
            begin
                set2[`EV_B8ZS_BIT] = 1'b1;
            end
        end

        // edges of the four alarm conditions
        cond = {remote_alarm_cond, all_ones_alarm_cond, s.los, frame_loss_cond};
        set1[3:0] = cond & ~s.cond_prev;
        set1[7:4] = ~cond & s.cond_prev;
        n.cond_prev = cond;

        // T1 framing bit checks
        if (!s.e1_mode && framing_bit_strobe)
        begin
            n.fbit_hist = {s.fbit_hist[4:0], framing_bit_error};
            if (framing_bit_error)
            begin
                set2[`EV_FBE_BIT] = 1'b1;
            end
            // two errors among the last six
            if (count_ones({2'h0, n.fbit_hist}) >= `SEVERE_FRAMING_ERR_EVT_ERRS)
            begin
                set2[`EV_SEVERE_FRAMING_ERR_EVT_BIT] = 1'b1;
            end
        end

        // errored CRC words in a 1000-word window
        if (s.e1_mode && crc_word_strobe)
        begin
            n.crc_words = s.crc_words + 10'h001;
            if (crc_word_error)
            begin
                n.crc_errs = s.crc_errs + 10'h001;
                if (n.crc_errs == `CRC_THRESH)
                begin
                    set2[`EV_CRC_RESYNC_CRITERIA_EVT_BIT] = 1'b1;
                end
            end
            if (n.crc_words == `CRC_WINDOW)
            begin
                n.crc_words = 10'h000;
                n.crc_errs = 10'h000;
            end
        end

        if (s.e1_mode && cas_mfas_strobe)
        begin
            if (cas_mfas_error && s.cas_prev_err)
            begin
                set2[`EV_CAS_RESYNC_CRITERIA_EVT_BIT] = 1'b1;
            end
            n.cas_prev_err = cas_mfas_error;
        end
        if (s.e1_mode && fas_strobe)
        begin
            n.fas_run = fas_error ? ((s.fas_run == `FAS_RUN) ? s.fas_run
                        : s.fas_run + 2'h1) : 2'h0;
            if (fas_error && n.fas_run == `FAS_RUN)
            begin
                set2[`EV_FAS_RESYNC_CRITERIA_EVT_BIT] = 1'b1;
            end
        end

        // slot 16 windows of 16 frames, realigned at the multiframe start
        if (s.e1_mode && ts16_strobe)
        begin
            if (cas_mf_start)
            begin
                n.ts16_frames = 4'h0;
                n.ts16_zeros = 8'h00;
                n.ts16_any_one = 1'b0;
            end
            n.ts16_zeros = n.ts16_zeros + {4'h0, 4'h8 - count_ones(ts16_data)};
            n.ts16_any_one = n.ts16_any_one || (ts16_data != 8'h00);
            if (n.ts16_frames == `TS16_LAST_FRAME)
            begin
                // under three zeros, also in CCS
                if (n.ts16_zeros < `SA1_ZEROS)
                begin
                    set2[`EV_SA1_BIT] = 1'b1;
                end
                if (!n.ts16_any_one)
                begin
                    set2[`EV_SA0_BIT] = 1'b1;
                end
                n.ts16_frames = 4'h0;
                n.ts16_zeros = 8'h00;
                n.ts16_any_one = 1'b0;
            end
            else
            begin
                n.ts16_frames = n.ts16_frames + 4'h1;
            end
        end

        // CRC-4 boundary, else a free 2 ms tick
        if (crc4_enable)
        begin
            n.mf_timer = 16'h0000;
            if (s.e1_mode && crc4_mf_boundary)
            begin
                set2[`EV_CMF_BIT] = 1'b1;
            end
        end
        else if (s.mf_timer == 16'(MF_TIMER_CYCLES - 1))
        begin
            n.mf_timer = 16'h0000;
            set2[`EV_CMF_BIT] = s.e1_mode;
        end
        else
        begin
            n.mf_timer = s.mf_timer + 16'h0001;
        end

        // a set in the clearing cycle survives
        n.rx_latched_alarm_status = (s.rx_latched_alarm_status & ~clr1) | set1;
        n.rls2 = (s.rls2 & ~clr2) | set2;
        n.irq = (|n.rx_latched_alarm_status) || (n.e1_mode && |(n.rls2 & `E1_IRQ_MASK));

        // BERT bit path; valid stays low when gated off, but data still follows the selected source on every strobe
        n.bert_valid = 1'b0;
        if (bert_bit_strobe)
        begin
            n.bert_valid = s.bert_ctl[`BERT_EN_BIT]
                && !s.suppress[bert_bit_index]
                && !(!s.e1_mode && bert_fbit && !s.bert_ctl[`BERT_FRM_BIT]);
            n.bert_data = s.bert_ctl[`BERT_DIR_BIT] ? tx_path_bit
                          : rx_framer_bit;
        end
    end

    // whole state register; every field resets to zero
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign interleave_bus_enable = s.ibo[`IBO_EN_BIT];
    assign bus_position_select = s.ibo[2:0];
    assign bus_slot_onehot = s.bus_slot;
    assign spare_code_length_sel = s.spare;
    assign spare_code_bits = s.spare_len;
    assign spare_code_long = s.spare_long;
    assign bert_source_direction = s.bert_ctl[`BERT_DIR_BIT];
    assign bert_framing_select = s.bert_ctl[`BERT_FRM_BIT];
    assign bert_port_enable = s.bert_ctl[`BERT_EN_BIT];
    assign chan_bit_suppress = s.suppress;
    assign signal_loss_cond = s.los;
    assign e1_mode = s.e1_mode;
    assign bert_bit_data = s.bert_data;
    assign bert_bit_valid = s.bert_valid;
    assign irq_req = s.irq;

    // checks on the state; all in the ref_clk domain
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_los_at_count: assert property ($rose(s.los) |-> s.zero_cnt == 8'hC0
                                     && $past(s.zero_cnt) == 8'hBF)
        else $error("loss of signal not at zero count 192");
    a_lof_rise_flag: assert property ($rose(frame_loss_cond) |=> s.rx_latched_alarm_status[0])
        else $error("frame loss detect flag missed");
    a_lof_fall_flag: assert property ($fell(frame_loss_cond) |=> s.rx_latched_alarm_status[4])
        else $error("frame loss clear flag missed");
    a_sticky_status: assert property (|($past(s.rx_latched_alarm_status) & ~s.rx_latched_alarm_status & ~$past(clr1))
                                      == 1'b0)
        else $error("latched alarm bit dropped without a clear");
    a_irq_sources: assert property (irq_req == ((|s.rx_latched_alarm_status)
                   || (s.e1_mode && |s.rls2[3:0])))
        else $error("interrupt does not match latched sources");
    a_fas_three: assert property (s.e1_mode && fas_strobe && fas_error
                                  && s.fas_run == 2'h2 |=> s.rls2[4])
        else $error("third errored FAS word not latched");
    a_crc_thresh: assert property (s.e1_mode && crc_word_strobe
                  && crc_word_error && s.crc_errs == 10'h392
                  && s.crc_words != 10'h3E7 |=> s.rls2[6])
        else $error("CRC resync criteria not latched at 915");
    a_bert_off: assert property (!s.bert_ctl[0] |=> !bert_bit_valid)
        else $error("BERT valid while port disabled");
    a_bert_suppress: assert property (bert_bit_strobe
                     && s.suppress[bert_bit_index] |=> !bert_bit_valid)
        else $error("suppressed channel bit passed to BERT");
    a_bert_fbit: assert property (!s.e1_mode && bert_bit_strobe && bert_fbit
                 && !s.bert_ctl[1] |=> !bert_bit_valid)
        else $error("framed F-bit passed to BERT");
    a_eight_zeros: assert property (!s.e1_mode && line_bit_en && line_zero
                   && s.zero_cnt == 8'h07 |=> s.rls2[4])
        else $error("eight zero run not latched");

    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
    c_los_rise: cover property ($rose(s.los));
    c_crc_event: cover property (s.e1_mode && $rose(s.rls2[6]));

endmodule
`default_nettype wire

// file: rtl/rx_status_defs.svh
// register indices, field positions and timing counts for the receive
// control and latched-status bank; included by the bank module only.
`ifndef RX_STATUS_DEFS_SVH
`define RX_STATUS_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_IBO_CTL 10'h088
`define IDX_SPARE_CTL 10'h089
`define IDX_BERT_CTL 10'h08A
`define IDX_BERT_SUPPRESS 10'h08B
`define IDX_ALARM_STATUS 10'h090
`define IDX_EVENT_STATUS 10'h091
`define IDX_CODE_STATUS 10'h092
`define IDX_LINE_MODE 10'h0A0

// reset value shared by every register of the bank
`define REG_RESET 8'h00

// interleave control fields
`define IBO_EN_BIT 3

// receive BERT port control fields
`define BERT_DIR_BIT 2
`define BERT_FRM_BIT 1
`define BERT_EN_BIT 0

// line mode register field
`define E1_MODE_BIT 0

// second latched register, T1 meaning
`define EV_PDV_BIT 7
`define EV_ZERO8_BIT 4
`define EV_ZERO16_BIT 3
`define EV_SEVERE_FRAMING_ERR_EVT_BIT 2
`define EV_B8ZS_BIT 1
`define EV_FBE_BIT 0

// second latched register, E1 meaning
`define EV_CRC_RESYNC_CRITERIA_EVT_BIT 6
`define EV_CAS_RESYNC_CRITERIA_EVT_BIT 5
`define EV_FAS_RESYNC_CRITERIA_EVT_BIT 4
`define EV_SA1_BIT 3
`define EV_SA0_BIT 2
`define EV_CMF_BIT 1
`define E1_IRQ_MASK 8'h0F

// line and framing counts
`define LOS_ZEROS 8'hC0
`define ZERO_RUN_SHORT 8'h08
`define ZERO_RUN_LONG 8'h10
`define SEVERE_FRAMING_ERR_EVT_ERRS 4'h2
`define CRC_WINDOW 10'h3E8
`define CRC_THRESH 10'h393
`define FAS_RUN 2'h3
`define TS16_LAST_FRAME 4'hF
`define SA1_ZEROS 8'h03

// timing: multiframe period and clock rate
`define MF_PERIOD_US 2000
`define CLK_MHZ 25

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/rx_status_pkg.sv
// types for the receive control and latched-status bank.
// assumes the bank keeps all of its state in one registered struct.
package rx_status_pkg;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [9:0] aw_idx;
        logic [7:0] wbyte;
        logic wlane;
        logic [3:0] ibo;
        logic [7:0] bus_slot;
        logic [2:0] spare;
        logic [3:0] spare_len;
        logic spare_long;
        logic [2:0] bert_ctl;
        logic [7:0] suppress;
        logic e1_mode;
        logic [7:0] rx_latched_alarm_status;
        logic [7:0] rls2;
        logic [3:0] cond_prev;
        logic pos_s1;
        logic pos_s2;
        logic neg_s1;
        logic neg_s2;
        logic [7:0] zero_cnt;
        logic los;
        logic [15:0] sym_hist;
        logic pol_before;
        logic [5:0] fbit_hist;
        logic [9:0] crc_words;
        logic [9:0] crc_errs;
        logic cas_prev_err;
        logic [1:0] fas_run;
        logic [3:0] ts16_frames;
        logic [7:0] ts16_zeros;
        logic ts16_any_one;
        logic [15:0] mf_timer;
        logic bert_data;
        logic bert_valid;
        logic irq;
    } bank_state_t;

endpackage
